// ===== include/temp_index_pkg.sv
package temp_index_pkg;

  // Register offsets on the internal byte address port
  localparam logic [7:0] temperature_index_offset = 8'h81;
  localparam logic [7:0] resistor_zero_position_offset = 8'h82;
  localparam logic [7:0] resistor_one_position_offset = 8'h83;
  localparam logic [7:0] event_interrupt_mask_offset = 8'h88;
  localparam logic [7:0] device_configuration_offset = 8'h89;

  // Look-up table window that the index points into
  localparam logic [7:0] lookup_first_address = 8'h80;
  localparam logic [7:0] lookup_last_address = 8'hC7;
  localparam logic [7:0] lookup_index_max = 8'h47;

  // Reset values
  localparam logic [7:0] temperature_index_reset = 8'h00;
  localparam logic [7:0] resistor_position_reset = 8'hFF;
  localparam logic [7:0] event_interrupt_mask_reset = 8'hF8;
  localparam logic [7:0] device_configuration_reset = 8'h00;

  // Writable bits: mask bits 7..3, configuration bits 5..0
  localparam logic [7:0] event_interrupt_mask_writable = 8'hF8;
  localparam logic [7:0] device_configuration_writable = 8'h3F;

  // Field positions
  localparam int temperature_event_bit = 7;
  localparam int supply_event_bit = 6;
  localparam int first_monitor_event_bit = 5;
  localparam int second_monitor_event_bit = 4;
  localparam int third_monitor_event_bit = 3;
  localparam int buffer_one_invert_bit = 1;
  localparam int event_count = 5;

  // Monitor event levels, one per channel
  typedef struct packed {
    logic temperature;
    logic supply;
    logic first_monitor;
    logic second_monitor;
    logic third_monitor;
  } event_levels_t;

  // Look-up table entries for the current index
  typedef struct packed {
    logic [7:0] resistor_zero;
    logic [7:0] resistor_one;
  } table_entry_t;

endpackage

// ===== hw/event_flag_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module event_flag_buffer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Event sources and configuration
  input wire logic [4:0] event_levels,
  input wire logic [4:0] event_enables,
  input wire logic buffer_one_invert,
  // Buffer pin
  input wire logic buffer_one_input,
  // Results
  output logic masked_interrupt_flag,
  output logic buffer_one_output
);

  // All state of the flag and buffer path
  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic flag;
    logic out;
  } buffer_state_t;

  buffer_state_t s; // Current state
  buffer_state_t next_s; // Next state

  // Flag follows enabled events; output merges flag with pin
  always_comb begin
    next_s = s;
    next_s.sync_first = buffer_one_input;
    next_s.sync_second = s.sync_first;
    next_s.flag = |(event_levels & event_enables);
    next_s.out = next_s.flag | (buffer_one_invert ^ s.sync_second);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign masked_interrupt_flag = s.flag;
  assign buffer_one_output = s.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  flag_from_event_a: assert property (
    |(event_levels & event_enables) |=> masked_interrupt_flag)
    else $error("Enabled event did not raise the flag");

  flag_masked_off_a: assert property (
    (event_enables == 5'h00) |=> !masked_interrupt_flag)
    else $error("Flag set with all events masked");

  output_equation_a: assert property (
    $past(rst_n) |-> buffer_one_output ==
      (masked_interrupt_flag | ($past(buffer_one_invert) ^ $past(s.sync_second))))
    else $error("Buffer output does not match flag and pin");

endmodule
`default_nettype wire

// ===== hw/temp_index_resistor_regs.sv
// Overview of operation
// - Index, host-writable in test mode, selecting table entries 80h-C7h
// - Resistor zero position byte, read/write, reset FF
// - Resistor one position byte, read/write, reset FF
// - Enabled events set flag, driving buffer one
// - Mask bits 7..3 enable channels, default one
// - Lookup off: host writes set the resistors
// - Index auto off: host writes the index
// - Buffer output is flag OR invert XOR input
`timescale 1ns/1ns
`default_nettype none
module temp_index_resistor_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Mode bits held elsewhere
  input wire logic auto_lookup_enable,
  input wire logic auto_index_enable,
  // Temperature and table path
  input wire logic [7:0] computed_index,
  input wire temp_index_pkg::table_entry_t table_entry,
  output logic [7:0] lookup_address,
  // Monitor events
  input wire temp_index_pkg::event_levels_t event_levels,
  // Resistor settings
  output logic [7:0] resistor_zero_position,
  output logic [7:0] resistor_one_position,
  // Buffer one pin and flag
  input wire logic buffer_one_input,
  output logic masked_interrupt_flag,
  output logic buffer_one_output
);

  // All register state of the slice
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] res_zero;
    logic [7:0] res_one;
    logic [7:0] mask;
    logic [7:0] config_byte;
    logic [7:0] rdata;
    logic [7:0] lut_addr;
  } regs_state_t;

  regs_state_t s; // Current state
  regs_state_t next_s; // Next state
  logic [4:0] event_enables; // Mask bits 7..3 in channel order
  logic [7:0] clamped_index; // Index limited to the table span

  // Write strobe decode for one offset
  function automatic logic wr_hit(input logic [7:0] addr,
                                  input logic wr,
                                  input logic [7:0] offset);
    wr_hit = wr && (addr == offset);
  endfunction

  // Clamp keeps the table address inside 80h..C7h
  always_comb begin
    if (s.index > temp_index_pkg::lookup_index_max) begin
      clamped_index = temp_index_pkg::lookup_index_max;
    end else begin
      clamped_index = s.index;
    end
  end

  // Next-state logic for every register
  always_comb begin
    next_s = s;
    // Index source: sensor or host in test mode
    if (auto_index_enable) begin
      next_s.index = computed_index;
    end else if (wr_hit(reg_addr, reg_wr,
                 temp_index_pkg::temperature_index_offset)) begin
      next_s.index = reg_wdata;
    end
    next_s.lut_addr = temp_index_pkg::lookup_first_address
                      + clamped_index;
    // Resistor positions: table wins while lookup is on
    if (auto_lookup_enable) begin
      next_s.res_zero = table_entry.resistor_zero;
      next_s.res_one = table_entry.resistor_one;
    end else begin
      if (wr_hit(reg_addr, reg_wr,
                 temp_index_pkg::resistor_zero_position_offset)) begin
        next_s.res_zero = reg_wdata;
      end
      if (wr_hit(reg_addr, reg_wr,
                 temp_index_pkg::resistor_one_position_offset)) begin
        next_s.res_one = reg_wdata;
      end
    end
    // Mask keeps only the five channel bits
    if (wr_hit(reg_addr, reg_wr,
               temp_index_pkg::event_interrupt_mask_offset)) begin
      next_s.mask = reg_wdata
                    & temp_index_pkg::event_interrupt_mask_writable;
    end
    // Configuration: bits 7 and 6 stay zero
    if (wr_hit(reg_addr, reg_wr,
               temp_index_pkg::device_configuration_offset)) begin
      next_s.config_byte = reg_wdata
                           & temp_index_pkg::device_configuration_writable;
    end
    // Read data, unmapped offsets read zero
    unique case (reg_addr)
      temp_index_pkg::temperature_index_offset: begin
        next_s.rdata = s.index;
      end
      temp_index_pkg::resistor_zero_position_offset: begin
        next_s.rdata = s.res_zero;
      end
      temp_index_pkg::resistor_one_position_offset: begin
        next_s.rdata = s.res_one;
      end
      temp_index_pkg::event_interrupt_mask_offset: begin
        next_s.rdata = s.mask;
      end
      temp_index_pkg::device_configuration_offset: begin
        next_s.rdata = s.config_byte;
      end
      default: begin
        next_s.rdata = 8'h00;
      end
    endcase
  end

  // State register with power-on defaults
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s.index <= temp_index_pkg::temperature_index_reset;
      s.res_zero <= temp_index_pkg::resistor_position_reset;
      s.res_one <= temp_index_pkg::resistor_position_reset;
      s.mask <= temp_index_pkg::event_interrupt_mask_reset;
      s.config_byte <= temp_index_pkg::device_configuration_reset;
      s.rdata <= 8'h00;
      s.lut_addr <= temp_index_pkg::lookup_first_address;
    end else begin
      s <= next_s;
    end
  end

  // Mask bits in channel order for the flag logic
  assign event_enables = {
    s.mask[temp_index_pkg::temperature_event_bit],
    s.mask[temp_index_pkg::supply_event_bit],
    s.mask[temp_index_pkg::first_monitor_event_bit],
    s.mask[temp_index_pkg::second_monitor_event_bit],
    s.mask[temp_index_pkg::third_monitor_event_bit]};

  // Flag and buffer one output
  event_flag_buffer flag_path (
    .clk(clk),
    .rst_n(rst_n),
    .event_levels(event_levels),
    .event_enables(event_enables),
    .buffer_one_invert(s.config_byte[temp_index_pkg::buffer_one_invert_bit]),
    .buffer_one_input(buffer_one_input),
    .masked_interrupt_flag(masked_interrupt_flag),
    .buffer_one_output(buffer_one_output)
  );

  assign reg_rdata = s.rdata;
  assign lookup_address = s.lut_addr;
  assign resistor_zero_position = s.res_zero;
  assign resistor_one_position = s.res_one;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Manual write to a resistor register
  sequence manual_zero_write;
    !auto_lookup_enable && reg_wr
      && reg_addr == temp_index_pkg::resistor_zero_position_offset;
  endsequence

  zero_manual_write_a: assert property (
    manual_zero_write |=> resistor_zero_position == $past(reg_wdata))
    else $error("Resistor zero write not taken");

  one_manual_write_a: assert property (
    !auto_lookup_enable && reg_wr
      && reg_addr == temp_index_pkg::resistor_one_position_offset
    |=> resistor_one_position == $past(reg_wdata))
    else $error("Resistor one write not taken");

  manual_hold_a: assert property (
    !auto_lookup_enable && !reg_wr |=> $stable(resistor_zero_position)
      && $stable(resistor_one_position))
    else $error("Resistor changed without a write");

  table_load_a: assert property (
    auto_lookup_enable |=> resistor_zero_position
      == $past(table_entry.resistor_zero)
      && resistor_one_position == $past(table_entry.resistor_one))
    else $error("Resistor not loaded from table");

  index_auto_a: assert property (
    auto_index_enable |=> s.index == $past(computed_index))
    else $error("Index not taken from sensor");

  index_manual_a: assert property (
    !auto_index_enable && reg_wr
      && reg_addr == temp_index_pkg::temperature_index_offset
    |=> s.index == $past(reg_wdata))
    else $error("Test mode index write not taken");

  lookup_span_a: assert property (
    lookup_address >= temp_index_pkg::lookup_first_address
      && lookup_address <= temp_index_pkg::lookup_last_address)
    else $error("Table address outside its span");

  // Mask written, then its offset addressed for a read
  sequence mask_write_then_read;
    reg_wr && reg_addr == temp_index_pkg::event_interrupt_mask_offset
      ##1 reg_addr == temp_index_pkg::event_interrupt_mask_offset;
  endsequence

  mask_write_read_a: assert property (
    mask_write_then_read |=> reg_rdata == ($past(reg_wdata, 2)
      & temp_index_pkg::event_interrupt_mask_writable))
    else $error("Mask readback wrong");

endmodule
`default_nettype wire

// ===== dv/lookup_table_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side look-up table: one entry pair for each table address
module lookup_table_model (
  // Table address from the block
  input wire logic [7:0] lookup_address,
  // Entry pair handed back
  output temp_index_pkg::table_entry_t table_entry
);
  // Entries differ per address so a wrong address shows at once
  always_comb begin
    table_entry.resistor_zero = lookup_address ^ 8'h5A;
    table_entry.resistor_one = ~lookup_address;
  end
endmodule
`default_nettype wire

// ===== dv/temp_index_resistor_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module temp_index_resistor_regs_tb_top;
  // Clock, reset and register port
  logic clk, rst_n, reg_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  // Mode, index and table path
  logic auto_lookup_enable, auto_index_enable;
  logic [7:0] computed_index, lookup_address, pos_zero, pos_one;
  temp_index_pkg::table_entry_t table_entry;
  // Events and buffer pin
  temp_index_pkg::event_levels_t event_levels;
  logic buffer_one_input, masked_interrupt_flag, buffer_one_output;
  // Run bookkeeping
  int n_mismatch = 0;
  int compares = 0;

  // Device slice under test
  temp_index_resistor_regs uut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .auto_lookup_enable(auto_lookup_enable),
    .auto_index_enable(auto_index_enable),
    .computed_index(computed_index), .table_entry(table_entry),
    .lookup_address(lookup_address), .event_levels(event_levels),
    .resistor_zero_position(pos_zero), .resistor_one_position(pos_one),
    .buffer_one_input(buffer_one_input),
    .masked_interrupt_flag(masked_interrupt_flag),
    .buffer_one_output(buffer_one_output));

  // Table on the far side
  lookup_table_model table_far (.lookup_address(lookup_address),
    .table_entry(table_entry));

  // Clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compare one byte and report a difference
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  // Idle for a number of falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle write strobe, a free edge first so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // Read with one cycle of lag, then compare
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge clk);
    check(reg_rdata, exp, "read data");
  endtask

  // Values after reset, unmapped place included
  task automatic reset_values();
    rd(8'h81, 8'h00);
    rd(8'h82, 8'hFF);
    rd(8'h83, 8'hFF);
    rd(8'h88, 8'hF8);
    rd(8'h89, 8'h00);
    rd(8'h85, 8'h00);
    check(lookup_address, 8'h80, "lookup after reset");
    check({7'h00, buffer_one_output}, 8'h00, "buffer after reset");
  endtask

  // Manual positions, then table-driven positions and index clamp
  task automatic resistor_paths();
    wr(8'h82, 8'h00);
    wr(8'h83, 8'hA5);
    wr(8'h85, 8'h11);
    check(pos_zero, 8'h00, "manual zero");
    check(pos_one, 8'hA5, "manual one");
    rd(8'h83, 8'hA5);
    rd(8'h85, 8'h00);
    computed_index = 8'h10;
    auto_lookup_enable = 1'b1;
    cyc(4);
    check(lookup_address, 8'h90, "lookup address");
    check(pos_zero, 8'hCA, "table zero");
    check(pos_one, 8'h6F, "table one");
    // Looked at right after the write edge; the table load on that same edge keeps the write out
    wr(8'h82, 8'h33);
    check(pos_zero, 8'hCA, "write while table on");
    computed_index = 8'h47;
    cyc(3);
    check(lookup_address, 8'hC7, "last entry");
    computed_index = 8'h20;
    cyc(3);
    check(lookup_address, 8'hA0, "mid entry");
    computed_index = 8'hFF;
    cyc(3);
    check(lookup_address, 8'hC7, "clamped entry");
    auto_lookup_enable = 1'b0;
  endtask

  // Index written by host only in test mode
  task automatic index_modes();
    computed_index = 8'h22;
    cyc(2);
    wr(8'h81, 8'h77);
    rd(8'h81, 8'h22);
    auto_index_enable = 1'b0;
    wr(8'h81, 8'h3C);
    rd(8'h81, 8'h3C);
    cyc(2);
    check(lookup_address, 8'hBC, "test mode lookup");
    auto_index_enable = 1'b1;
  endtask

  // Each mask bit against its own and the other channels
  task automatic mask_channels();
    for (int i = 0; i < 5; i++) begin
      wr(8'h88, 8'h80 >> i);
      rd(8'h88, 8'h80 >> i);
      event_levels = 5'h10 >> i;
      cyc(2);
      check({7'h00, masked_interrupt_flag}, 8'h01, "own");
      check({7'h00, buffer_one_output}, 8'h01, "out");
      event_levels = ~(5'h10 >> i);
      cyc(2);
      check({7'h00, masked_interrupt_flag}, 8'h00, "other");
    end
    wr(8'h88, 8'h00);
    event_levels = 5'h1F;
    cyc(2);
    check({7'h00, masked_interrupt_flag}, 8'h00, "all off");
    wr(8'h88, 8'hFF);
    rd(8'h88, 8'hF8);
  endtask

  // Buffer output over invert, pin and flag
  task automatic buffer_table();
    wr(8'h89, 8'hFF);
    rd(8'h89, 8'h3F);
    for (int k = 0; k < 8; k++) begin
      wr(8'h89, {6'h00, k[2], 1'b0});
      buffer_one_input = k[1];
      event_levels = {k[0], 4'h0};
      cyc(4);
      check({7'h00, buffer_one_output},
            {7'h00, k[0] | (k[2] ^ k[1])}, "buffer");
    end
  endtask

  // Guard against a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    auto_lookup_enable = 1'b0;
    auto_index_enable = 1'b1;
    computed_index = 8'h00;
    event_levels = 5'h00;
    buffer_one_input = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    reset_values();
    resistor_paths();
    index_modes();
    mask_channels();
    buffer_table();
    wrap_up();
  end
endmodule
`default_nettype wire
